// [cfl_card_config_loader.sv]
// card configuration loader: sequencer on core clock, shifter on link clock
`default_nettype none

module cfl_card_config_loader #(
    parameter int P_MS_CYCLES = cfl_pkg::MS_CYCLES,
    parameter int P_POST_CLOCKS = cfl_pkg::POST_CLOCKS
) (
    // core clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    // link clock
    input wire logic I_LINK_CLK,
    // card byte stream
    input wire logic [cfl_pkg::DATA_W-1:0] I_CARD_DATA,
    input wire logic I_CARD_VALID,
    output logic O_CARD_READY,
    input wire logic I_CARD_INIT_DONE,
    // firmware settings
    input wire logic [cfl_pkg::PROG_WAIT_W-1:0] I_PROG_WAIT,
    input wire logic I_WIDE_MODE,
    // target status
    input wire logic I_LOAD_COMPLETE_IN,
    input wire logic I_LOAD_ERROR_STATUS_N,
    // open-drain start strobe
    input wire logic I_LOAD_START_STROBE_N,
    output logic O_LOAD_START_STROBE_N,
    output logic O_LOAD_START_STROBE_N_OE,
    // configuration outputs
    output logic O_LOAD_CLOCK_A,
    output logic O_LOAD_CLOCK_B,
    output logic [cfl_pkg::DATA_W-1:0] O_LOAD_DATA,
    // status
    output logic O_BUSY,
    output logic O_LOADED,
    output logic O_LOAD_FAILED
);
    localparam int TW = $clog2(P_MS_CYCLES);
    localparam int MW = cfl_pkg::MS_W;
    localparam int PW = cfl_pkg::POST_W;
    localparam int DW = cfl_pkg::DATA_W;

    // ------------------------------------------------------------------
    // core domain declarations
    // ------------------------------------------------------------------
    cfl_pkg::cfl_core_e state_reg;
    cfl_pkg::cfl_core_e state_next;
    logic [TW-1:0] tick_cnt_reg;
    logic [MW-1:0] ms_cnt_reg;
    logic ms_tick;
    logic [MW-1:0] prog_wait_ms;
    logic [4:0] core_sync;
    logic err_n_s;
    logic complete_s;
    logic strobe_n_s;
    logic ack_s;
    logic post_done_s;
    logic driving;
    logic seen_high_reg;
    logic ext_restart;
    logic err_restart;
    logic req_reg;
    logic [DW-1:0] byte_reg;
    logic wide_reg;
    logic slot_free;
    logic take;
    logic run_reg;
    logic post_reg;
    logic loaded_reg;
    logic failed_reg;

    // ------------------------------------------------------------------
    // link domain declarations
    // ------------------------------------------------------------------
    logic lrst1_reg;
    logic lrst_n_reg;
    logic [2:0] link_sync;
    logic run_s;
    logic post_s;
    logic req_s;
    cfl_pkg::cfl_link_e lstate_reg;
    logic lclk_reg;
    logic [DW-1:0] data_reg;
    logic [DW-1:0] sh_reg;
    logic [3:0] bits_reg;
    logic [PW-1:0] post_cnt_reg;
    logic ack_reg;
    logic post_done_reg;
    logic pending;

    // ------------------------------------------------------------------
    // pin and cross-domain synchronisers into the core domain
    // ------------------------------------------------------------------
    cfl_sync3 #(
        .W(5),
        .RST_VAL(cfl_pkg::CORE_SYNC_RST)
    ) u_core_sync (
        .i_clk(I_MCLK),
        .i_rst_n(I_RESET_N),
        .i_async({ack_reg, post_done_reg, I_LOAD_ERROR_STATUS_N,
                  I_LOAD_COMPLETE_IN, I_LOAD_START_STROBE_N}),
        .o_level(core_sync)
    );

    assign ack_s = core_sync[4];
    assign post_done_s = core_sync[3];
    assign err_n_s = core_sync[2];
    assign complete_s = core_sync[1];
    assign strobe_n_s = core_sync[0];

    // ------------------------------------------------------------------
    // millisecond timer, restarted on every state change
    // ------------------------------------------------------------------
    assign ms_tick = (tick_cnt_reg == TW'(P_MS_CYCLES - 1));

    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            tick_cnt_reg <= '0;
            ms_cnt_reg <= '0;
        end
        else if (state_next != state_reg)
        begin
            tick_cnt_reg <= '0;
            ms_cnt_reg <= '0;
        end
        else if (ms_tick)
        begin
            tick_cnt_reg <= '0;
            // saturate so a long stall cannot wrap back under a limit
            if (ms_cnt_reg != {MW{1'b1}})
            begin
                ms_cnt_reg <= ms_cnt_reg + MW'(1);
            end
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + TW'(1);
        end
    end

    // ------------------------------------------------------------------
    // start strobe and restart detection
    // ------------------------------------------------------------------
    // controller drives the strobe low itself during card init and while pulsing
    assign driving = (state_reg == cfl_pkg::CS_CARD_INIT) ||
                     (state_reg == cfl_pkg::CS_PULSE);
    assign O_LOAD_START_STROBE_N = 1'b0;
    assign O_LOAD_START_STROBE_N_OE = driving;

    // the pulled-up line needs time to rise after release, so a low is only
    // taken as the board's request once it has been seen high again
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            seen_high_reg <= 1'b0;
        end
        else if (driving)
        begin
            seen_high_reg <= 1'b0;
        end
        else if (strobe_n_s)
        begin
            seen_high_reg <= 1'b1;
        end
    end

    assign ext_restart = !driving && seen_high_reg && !strobe_n_s;
    assign err_restart = !err_n_s &&
                         ((state_reg == cfl_pkg::CS_PROG_WAIT) ||
                          (state_reg == cfl_pkg::CS_FIRST_DLY) ||
                          (state_reg == cfl_pkg::CS_LOAD));

    assign prog_wait_ms = MW'(I_PROG_WAIT) * cfl_pkg::PROG_WAIT_STEP_MS;

    // ------------------------------------------------------------------
    // load sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            cfl_pkg::CS_CARD_INIT:
            begin
                // card type decides how much beyond the minimum is spent here
                if ((ms_cnt_reg >= cfl_pkg::CARD_INIT_MS) && I_CARD_INIT_DONE)
                begin
                    state_next = cfl_pkg::CS_PULSE;
                end
            end
            cfl_pkg::CS_PULSE:
            begin
                if (ms_cnt_reg >= cfl_pkg::START_PULSE_MS)
                begin
                    state_next = cfl_pkg::CS_WAIT_REL;
                end
            end
            cfl_pkg::CS_WAIT_REL:
            begin
                if (err_n_s)
                begin
                    state_next = cfl_pkg::CS_PROG_WAIT;
                end
            end
            cfl_pkg::CS_PROG_WAIT:
            begin
                if (ms_cnt_reg >= prog_wait_ms)
                begin
                    state_next = cfl_pkg::CS_FIRST_DLY;
                end
            end
            cfl_pkg::CS_FIRST_DLY:
            begin
                // data availability then stretches this further
                if (ms_cnt_reg >= cfl_pkg::FIRST_DATA_DELAY_MS)
                begin
                    state_next = cfl_pkg::CS_LOAD;
                end
            end
            cfl_pkg::CS_LOAD:
            begin
                if (complete_s)
                begin
                    state_next = cfl_pkg::CS_POST;
                end
            end
            cfl_pkg::CS_POST:
            begin
                if (post_done_s)
                begin
                    state_next = cfl_pkg::CS_DONE;
                end
            end
            cfl_pkg::CS_DONE:
            begin
                state_next = cfl_pkg::CS_DONE;
            end
            default:
            begin
                state_next = cfl_pkg::CS_CARD_INIT;
            end
        endcase
        if (ext_restart || err_restart)
        begin
            state_next = cfl_pkg::CS_PULSE;
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            state_reg <= cfl_pkg::CS_CARD_INIT;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // run and post levels toward the link domain
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            run_reg <= 1'b0;
            post_reg <= 1'b0;
        end
        else
        begin
            run_reg <= (state_next == cfl_pkg::CS_LOAD) ||
                       (state_next == cfl_pkg::CS_POST);
            post_reg <= (state_next == cfl_pkg::CS_POST);
        end
    end

    // ------------------------------------------------------------------
    // byte slot, toggle handshake to the link
    // ------------------------------------------------------------------
    assign slot_free = (req_reg == ack_s);
    assign O_CARD_READY = (state_reg == cfl_pkg::CS_LOAD) && slot_free;
    assign take = O_CARD_READY && I_CARD_VALID;

    // byte and mode stay still while the request is outstanding
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            req_reg <= 1'b0;
            byte_reg <= '0;
            wide_reg <= 1'b0;
        end
        else if (take)
        begin
            req_reg <= !req_reg;
            byte_reg <= I_CARD_DATA;
            wide_reg <= I_WIDE_MODE;
        end
    end

    // ------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            loaded_reg <= 1'b0;
            failed_reg <= 1'b0;
        end
        else
        begin
            loaded_reg <= (state_next == cfl_pkg::CS_DONE);
            if (err_restart)
            begin
                failed_reg <= 1'b1;
            end
            else if (state_next == cfl_pkg::CS_DONE)
            begin
                failed_reg <= 1'b0;
            end
        end
    end

    assign O_BUSY = (state_reg != cfl_pkg::CS_DONE);
    assign O_LOADED = loaded_reg;
    assign O_LOAD_FAILED = failed_reg;

    // ------------------------------------------------------------------
    // link domain reset release and synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge I_LINK_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            lrst1_reg <= 1'b0;
            lrst_n_reg <= 1'b0;
        end
        else
        begin
            lrst1_reg <= 1'b1;
            lrst_n_reg <= lrst1_reg;
        end
    end

    cfl_sync3 #(
        .W(3),
        .RST_VAL(cfl_pkg::LINK_SYNC_RST)
    ) u_link_sync (
        .i_clk(I_LINK_CLK),
        .i_rst_n(lrst_n_reg),
        .i_async({req_reg, post_reg, run_reg}),
        .o_level(link_sync)
    );

    assign req_s = link_sync[2];
    assign post_s = link_sync[1];
    assign run_s = link_sync[0];
    assign pending = (req_s != ack_reg);

    // ------------------------------------------------------------------
    // link shifter: load clock is link clock divided by two, data changes
    // on its falling edge so the target samples mid-cell on the rise
    // ------------------------------------------------------------------
    always_ff @(posedge I_LINK_CLK or negedge lrst_n_reg)
    begin
        if (!lrst_n_reg)
        begin
            lstate_reg <= cfl_pkg::LS_IDLE;
            lclk_reg <= 1'b0;
            data_reg <= '0;
            sh_reg <= '0;
            bits_reg <= '0;
            post_cnt_reg <= '0;
            ack_reg <= 1'b0;
            post_done_reg <= 1'b0;
        end
        else
        begin
            if (!post_s)
            begin
                post_done_reg <= 1'b0;
            end
            case (lstate_reg)
                cfl_pkg::LS_IDLE:
                begin
                    lclk_reg <= 1'b0;
                    if (pending && !run_s)
                    begin
                        // stale byte from an aborted load is dropped
                        ack_reg <= !ack_reg;
                    end
                    else if (pending && run_s)
                    begin
                        lstate_reg <= cfl_pkg::LS_SHIFT;
                        if (wide_reg)
                        begin
                            data_reg <= byte_reg;
                            bits_reg <= cfl_pkg::WIDE_BITS;
                        end
                        else
                        begin
                            data_reg <= {{(DW-1){1'b0}}, byte_reg[0]};
                            sh_reg <= byte_reg >> 1;
                            bits_reg <= cfl_pkg::SERIAL_BITS;
                        end
                    end
                    else if (post_s && !post_done_reg)
                    begin
                        lstate_reg <= cfl_pkg::LS_POST;
                        post_cnt_reg <= '0;
                    end
                end
                cfl_pkg::LS_SHIFT:
                begin
                    if (!run_s)
                    begin
                        lstate_reg <= cfl_pkg::LS_IDLE;
                        lclk_reg <= 1'b0;
                    end
                    else if (!lclk_reg)
                    begin
                        lclk_reg <= 1'b1;
                    end
                    else
                    begin
                        lclk_reg <= 1'b0;
                        if (bits_reg == cfl_pkg::WIDE_BITS)
                        begin
                            ack_reg <= !ack_reg;
                            lstate_reg <= cfl_pkg::LS_IDLE;
                        end
                        else
                        begin
                            bits_reg <= bits_reg - 4'h1;
                            data_reg <= {{(DW-1){1'b0}}, sh_reg[0]};
                            sh_reg <= sh_reg >> 1;
                        end
                    end
                end
                cfl_pkg::LS_POST:
                begin
                    if (!run_s)
                    begin
                        lstate_reg <= cfl_pkg::LS_IDLE;
                        lclk_reg <= 1'b0;
                    end
                    else if (!lclk_reg)
                    begin
                        lclk_reg <= 1'b1;
                    end
                    else
                    begin
                        lclk_reg <= 1'b0;
                        if (post_cnt_reg == PW'(P_POST_CLOCKS - 1))
                        begin
                            post_done_reg <= 1'b1;
                            lstate_reg <= cfl_pkg::LS_IDLE;
                        end
                        else
                        begin
                            post_cnt_reg <= post_cnt_reg + PW'(1);
                        end
                    end
                end
                default:
                begin
                    lstate_reg <= cfl_pkg::LS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs: both clock pins from one flop, data from flops
    // ------------------------------------------------------------------
    assign O_LOAD_CLOCK_A = lclk_reg;
    assign O_LOAD_CLOCK_B = lclk_reg;
    assign O_LOAD_DATA = data_reg;

endmodule

`default_nettype wire

// [cfl_pkg.sv]
// constants, state types and the pin synchroniser for the card config loader
`default_nettype none

package cfl_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 50;
    localparam int NS_PER_MS = 1000000;
    // one millisecond, rounded up to whole core clock cycles
    localparam int MS_CYCLES = (NS_PER_MS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int MS_W = 12;
    localparam logic [MS_W-1:0] START_PULSE_MS = 12'h008;
    localparam logic [MS_W-1:0] CARD_INIT_MS = 12'h12C;
    localparam logic [MS_W-1:0] FIRST_DATA_DELAY_MS = 12'h0FA;
    localparam logic [MS_W-1:0] PROG_WAIT_STEP_MS = 12'h00A;
    localparam int PROG_WAIT_W = 8;
    localparam logic [PROG_WAIT_W-1:0] PROG_WAIT_DFLT = 8'h00;

    // ------------------------------------------------------------------
    // link side
    // ------------------------------------------------------------------
    localparam int POST_CLOCKS = 256;
    localparam int POST_CLOCKS_MAX = 512;
    localparam int POST_W = 10;
    localparam int DATA_W = 8;
    localparam logic [3:0] SERIAL_BITS = 4'h8;
    localparam logic [3:0] WIDE_BITS = 4'h1;

    // ------------------------------------------------------------------
    // synchroniser reset values
    // ------------------------------------------------------------------
    // core bundle: {ack, post_done, err_n, complete, strobe_n}
    localparam logic [4:0] CORE_SYNC_RST = 5'h05;
    // link bundle: {req, post, run}
    localparam logic [2:0] LINK_SYNC_RST = 3'h0;

    typedef enum logic [2:0] {
        CS_CARD_INIT,
        CS_PULSE,
        CS_WAIT_REL,
        CS_PROG_WAIT,
        CS_FIRST_DLY,
        CS_LOAD,
        CS_POST,
        CS_DONE
    } cfl_core_e;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_SHIFT,
        LS_POST
    } cfl_link_e;

endpackage

// ----------------------------------------------------------------------
// three-stage synchroniser, value taken once stages two and three agree
// ----------------------------------------------------------------------
module cfl_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // signals
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] agree;

    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            o_level <= RST_VAL;
        end
        else
        begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            o_level <= (s2_reg & agree) | (o_level & ~agree);
        end
    end
endmodule

`default_nettype wire

// [cfl_chk.sv]
// assertion checker for the card configuration loader
`default_nettype none
module cfl_chk #(
    parameter int P_MS_CYCLES = 20
) (
    // clocks and reset
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_LINK_CLK,
    // watched outputs
    input wire logic O_CARD_READY,
    input wire logic O_LOAD_START_STROBE_N,
    input wire logic O_LOAD_START_STROBE_N_OE,
    input wire logic O_LOAD_CLOCK_A,
    input wire logic O_LOAD_CLOCK_B,
    input wire logic [cfl_pkg::DATA_W-1:0] O_LOAD_DATA,
    input wire logic O_BUSY,
    input wire logic O_LOADED
);
    int oe_cnt;
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            oe_cnt <= 0;
        else
            oe_cnt <= O_LOAD_START_STROBE_N_OE ? oe_cnt + 1 : 0;
    end
    chk_clk_twin: assert property (
        @(posedge I_LINK_CLK) disable iff (!I_RESET_N)
        O_LOAD_CLOCK_A == O_LOAD_CLOCK_B) else $error("clocks differ");
    chk_clk_high: assert property (
        @(posedge I_LINK_CLK) disable iff (!I_RESET_N)
        $rose(O_LOAD_CLOCK_A) |=> !O_LOAD_CLOCK_A) else $error("long high");
    chk_data_hold: assert property (
        @(posedge I_LINK_CLK) disable iff (!I_RESET_N)
        $rose(O_LOAD_CLOCK_A) |-> $stable(O_LOAD_DATA))
        else $error("data moved at clock rise");
    chk_strobe_low: assert property (
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        O_LOAD_START_STROBE_N == 1'b0) else $error("strobe drives high");
    chk_pulse_len: assert property (
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        $fell(O_LOAD_START_STROBE_N_OE) |-> oe_cnt >= 8 * P_MS_CYCLES - 1)
        else $error("strobe pulse short");
    chk_ready_load: assert property (
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        O_CARD_READY |-> !O_LOAD_START_STROBE_N_OE && O_BUSY)
        else $error("ready outside load");
    chk_done_flag: assert property (
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        O_LOADED |-> !O_BUSY && !O_CARD_READY && !O_LOAD_START_STROBE_N_OE)
        else $error("loaded flag inconsistent");
    chk_done_quiet: assert property (
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        O_LOADED |-> !O_LOAD_CLOCK_A) else $error("clock runs after done");
    cover property (@(posedge I_MCLK) $fell(O_LOAD_START_STROBE_N_OE));
    cover property (@(posedge I_MCLK) O_CARD_READY);
    cover property (@(posedge I_MCLK) $rose(O_LOADED));
endmodule
bind cfl_card_config_loader cfl_chk #(.P_MS_CYCLES(P_MS_CYCLES)) cfl_chk_i (.*);
`default_nettype wire

// [cfl_target_model.sv]
// behavioural model of the logic device being configured
`default_nettype none
module cfl_target_model (
    // control
    input wire logic i_clk,
    input wire logic i_strobe_n,
    input wire logic i_inject_err,
    input wire logic i_finish,
    // configuration pins
    input wire logic i_load_clk,
    input wire logic [7:0] i_data,
    output logic o_err_n,
    output var logic o_complete,
    output var logic [7:0] o_shift,
    output var logic [7:0] o_bus
);
    logic [2:0] rel_reg = 3'h0;
    // error line lags the strobe release by a few cycles
    always_ff @(posedge i_clk)
    begin
        rel_reg <= {rel_reg[1:0], i_strobe_n & ~i_inject_err};
        o_complete <= i_strobe_n & (o_complete | i_finish);
    end
    assign o_err_n = &rel_reg;
    always_ff @(posedge i_load_clk)
    begin
        o_shift <= {i_data[0], o_shift[7:1]};
        o_bus <= i_data;
    end
endmodule
`default_nettype wire

// [cfl_card_config_loader_tb.sv]
// self-checking bench for the card configuration loader
`default_nettype none
module cfl_card_config_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MSC = 20;
    localparam int PC = 8;
    logic mclk = 0, lclk = 0, rst_n = 0, valid = 0, init_done = 0;
    logic wide = 0, board_n = 1, inject = 0, finish = 0;
    logic [7:0] data = 8'h00, prog_wait = 8'h01, bus, shift;
    logic rdy, drv, oe, ca, cb, busy, loaded, failed, err_n, done;
    logic [7:0] ldata;
    wire logic strobe_w;
    int bad_count = 0, compares = 0, post_n = 0, n;
    // rows: {wide, byte, bus value after last clock}
    logic [16:0] rows [5] = '{17'h0A501, 17'h03C00, 17'h08001,
                              17'h1F0F0, 17'h10F0F};
    assign strobe_w = oe ? drv : board_n;
    always #25 mclk = ~mclk;
    always #7.5 lclk = ~lclk;
    always @(posedge ca) if (done) post_n++;
    cfl_card_config_loader #(.P_MS_CYCLES(MSC), .P_POST_CLOCKS(PC))
    cfl_card_config_loader_i (.I_MCLK(mclk), .I_RESET_N(rst_n),
        .I_LINK_CLK(lclk), .I_CARD_DATA(data), .I_CARD_VALID(valid),
        .O_CARD_READY(rdy), .I_CARD_INIT_DONE(init_done),
        .I_PROG_WAIT(prog_wait), .I_WIDE_MODE(wide),
        .I_LOAD_COMPLETE_IN(done), .I_LOAD_ERROR_STATUS_N(err_n),
        .I_LOAD_START_STROBE_N(strobe_w), .O_LOAD_START_STROBE_N(drv),
        .O_LOAD_START_STROBE_N_OE(oe), .O_LOAD_CLOCK_A(ca),
        .O_LOAD_CLOCK_B(cb), .O_LOAD_DATA(ldata), .O_BUSY(busy),
        .O_LOADED(loaded), .O_LOAD_FAILED(failed));
    cfl_target_model cfl_target_model_i (.i_clk(mclk),
        .i_strobe_n(strobe_w), .i_inject_err(inject), .i_finish(finish),
        .i_load_clk(ca), .i_data(ldata), .o_err_n(err_n),
        .o_complete(done), .o_shift(shift), .o_bus(bus));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, e);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    function automatic logic sg(input int k);
        return k == 0 ? oe : k == 1 ? rdy : k == 2 ? err_n : loaded;
    endfunction
    // bounded wait, n counts falling edges
    task automatic wt(input int k, input logic v, output int n);
        n = 0;
        while (sg(k) !== v && n < 30000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 30000)
        begin
            chk("wait", 16'h0, 16'h1);
            print_verdict;
        end
    endtask
    task automatic send(input logic w, input logic [7:0] d);
        int m;
        wide = w;
        data = d;
        valid = 1'b1;
        wt(1, 1'b1, m);
        @(negedge mclk);
        valid = 1'b0;
        wt(1, 1'b1, m);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        // slow card: ready well after the minimum, so the exit must wait
        fork
        begin
            repeat (320 * MSC) @(negedge mclk);
            init_done = 1'b1;
        end
        join_none
        chk("oe", oe, 1);
        chk("busy", {busy, loaded}, 2);
        wt(0, 1'b0, n);
        chk("init", n >= 328 * MSC && n <= 328 * MSC + 40, 1);
        wt(2, 1'b1, n);
        wt(1, 1'b1, n);
        chk("delay", n >= 260 * MSC && n <= 260 * MSC + 20, 1);
        $display("test power-up done");
        foreach (rows[i])
        begin
            send(rows[i][16], rows[i][15:8]);
            if (!rows[i][16])
                chk("shift", shift, rows[i][15:8]);
            chk("bus", bus, rows[i][7:0]);
        end
        $display("test data rows done");
        finish = 1'b1;
        wt(3, 1'b1, n);
        chk("post", post_n, PC);
        chk("done", {busy, failed}, 0);
        // low long enough to pass the pin filter and start the pulse
        board_n = 1'b0;
        repeat (6) @(negedge mclk);
        board_n = 1'b1;
        finish = 1'b0;
        chk("restart", oe, 1);
        wt(0, 1'b0, n);
        chk("pulse", n >= 8 * MSC - 4 && n <= 8 * MSC + 10, 1);
        chk("loaded", loaded, 0);
        prog_wait = 8'h00;
        wt(2, 1'b1, n);
        wt(1, 1'b1, n);
        chk("delay0", n >= 250 * MSC && n <= 250 * MSC + 20, 1);
        valid = 1'b1;
        repeat (2) @(negedge mclk);
        inject = 1'b1;
        valid = 1'b0;
        wt(0, 1'b1, n);
        chk("abort", n < 20, 1);
        chk("failed", failed, 1);
        inject = 1'b0;
        $display("test restarts done");
        print_verdict;
    end
endmodule
`default_nettype wire
